// file: core/eesp_pkg.sv
package eesp_pkg;

  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int ARRAY_AW = 11;
  localparam int SECTOR_STEP = 64;

  // Word-aligned byte offsets of the software registers.
  localparam logic [ADDR_W-1:0] OFF_PROT_CFG = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_ARRAY_STATUS = 5'h04;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 5'h08;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR = 5'h0c;
  localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 5'h10;

  // Array address of the stored protect byte.
  localparam logic [ARRAY_AW-1:0] PROTECT_BYTE_ADDR = 11'h7fd;

  // Field positions.
  localparam int POS_OPEN = 7;
  localparam int POS_NV_LO = 4;
  localparam int POS_RANGE_OFF = 3;
  localparam int POS_SIZE_LO = 0;
  localparam int POS_VIOLATION = 0;
  localparam int POS_MASS_OK = 1;
  localparam int IRQ_VIOLATION = 0;
  localparam int IRQ_ALLOWED = 1;
  localparam int IRQ_W = 2;

  // Values after reset.
  localparam logic [IRQ_W-1:0] IRQ_EN_RESET = 2'h0;
  localparam logic [IRQ_W-1:0] IRQ_STAT_RESET = 2'h0;
  localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0000_0000;

  typedef struct packed {
    logic open_for_modify;
    logic [2:0] user_nv_flags;
    logic range_protect_off;
    logic [2:0] protect_size_sel;
  } eesp_prot_cfg_t;

  typedef enum logic [1:0] {
    EESP_CMD_PROGRAM,
    EESP_CMD_SECTOR_ERASE,
    EESP_CMD_MASS_ERASE
  } eesp_cmd_kind_t;

  typedef struct packed {
    eesp_cmd_kind_t kind;
    logic [ARRAY_AW-1:0] addr;
  } eesp_cmd_t;

  typedef enum logic {
    EESP_BUS_IDLE,
    EESP_BUS_ANSWER
  } eesp_bus_st_t;

endpackage

// file: core/eesp_prot_check.sv
`timescale 1ns/10ps
module eesp_prot_check #(
  parameter int AW = eesp_pkg::ARRAY_AW
) (
  // Configuration and request
  input wire eesp_pkg::eesp_prot_cfg_t cfg_in,
  input wire eesp_pkg::eesp_cmd_t cmd_in,
  // Verdict
  output logic allowed_out
);

  localparam logic [AW:0] ARRAY_TOP = (AW+1)'(1) << AW;

  initial
  begin
    if (AW < 10)
    begin
      $error("Array too small for the largest protected sector.");
    end
  end

  logic [AW:0] sector_base;
  logic in_sector;

  always_comb
  begin
    sector_base = ARRAY_TOP - (AW+1)'(eesp_pkg::SECTOR_STEP * (int'(cfg_in.protect_size_sel) + 1));
    in_sector = !cfg_in.range_protect_off && ({1'b0, cmd_in.addr} >= sector_base);
    case (cmd_in.kind)
      eesp_pkg::EESP_CMD_PROGRAM,
      eesp_pkg::EESP_CMD_SECTOR_ERASE:
      begin
        allowed_out = cfg_in.open_for_modify && !in_sector;
      end
      eesp_pkg::EESP_CMD_MASS_ERASE:
      begin
        allowed_out = cfg_in.open_for_modify && cfg_in.range_protect_off;
      end
      default:
      begin
        allowed_out = 1'b0;
      end
    endcase
  end

endmodule // eesp_prot_check

// file: core/eesp_top.sv
`timescale 1ns/10ps
module eesp_top (
  // Clock, reset and enable
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  // Avalon-MM slave
  input wire logic [eesp_pkg::ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [eesp_pkg::DATA_W-1:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [eesp_pkg::DATA_W-1:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Stored protect byte from the array
  input wire eesp_pkg::eesp_prot_cfg_t stored_prot_in,
  // Program and erase requests from the array controller
  input wire logic cmd_valid_in,
  input wire eesp_pkg::eesp_cmd_t cmd_in,
  output logic cmd_allow_out,
  output logic cmd_deny_out,
  // Protection state and interrupt
  output eesp_pkg::eesp_prot_cfg_t prot_cfg_out,
  output logic irq_out
);

  typedef struct packed {
    eesp_pkg::eesp_prot_cfg_t cfg;
    logic violation;
    logic [eesp_pkg::IRQ_W-1:0] irq_stat;
    logic [eesp_pkg::IRQ_W-1:0] irq_en;
    eesp_pkg::eesp_bus_st_t bus_st;
    logic wait_req;
    logic [eesp_pkg::DATA_W-1:0] rdata;
    logic allow;
    logic deny;
    logic irq;
  } eesp_state_t;

  eesp_state_t st;
  eesp_state_t next_st;
  logic cmd_allowed;

  function automatic logic hits(
    input logic [eesp_pkg::ADDR_W-1:0] addr,
    input logic [eesp_pkg::ADDR_W-1:0] off
  );
    hits = (addr == off);
  endfunction

  function automatic logic [eesp_pkg::DATA_W-1:0] read_word(
    input eesp_state_t s,
    input logic [eesp_pkg::ADDR_W-1:0] addr
  );
    logic [eesp_pkg::DATA_W-1:0] w;
    w = '0;
    if (hits(addr, eesp_pkg::OFF_PROT_CFG))
    begin
      w[7:0] = s.cfg;
    end
    else if (hits(addr, eesp_pkg::OFF_ARRAY_STATUS))
    begin
      w[eesp_pkg::POS_VIOLATION] = s.violation;
      w[eesp_pkg::POS_MASS_OK] = s.cfg.open_for_modify && s.cfg.range_protect_off;
    end
    else if (hits(addr, eesp_pkg::OFF_IRQ_STATUS))
    begin
      w[eesp_pkg::IRQ_W-1:0] = s.irq_stat;
    end
    else if (hits(addr, eesp_pkg::OFF_IRQ_ENABLE))
    begin
      w[eesp_pkg::IRQ_W-1:0] = s.irq_en;
    end
    else
    begin
      w = '0;
    end
    read_word = w;
  endfunction

  eesp_prot_check #(
    .AW(eesp_pkg::ARRAY_AW)
  ) u_check (
    .cfg_in(st.cfg),
    .cmd_in(cmd_in),
    .allowed_out(cmd_allowed)
  );

  always_comb
  begin
    next_st = st;
    next_st.allow = 1'b0;
    next_st.deny = 1'b0;

    // Every access waits exactly one cycle, so read data is registered
    // and the bus never sees a combinational path through the decode.
    case (st.bus_st)
      eesp_pkg::EESP_BUS_IDLE:
      begin
        if (avs_read_in || avs_write_in)
        begin
          next_st.wait_req = 1'b0;
          next_st.rdata = read_word(st, avs_address_in);
          next_st.bus_st = eesp_pkg::EESP_BUS_ANSWER;
        end
      end
      eesp_pkg::EESP_BUS_ANSWER:
      begin
        next_st.wait_req = 1'b1;
        next_st.bus_st = eesp_pkg::EESP_BUS_IDLE;
        if (avs_write_in && avs_byteenable_in[0])
        begin
          if (hits(avs_address_in, eesp_pkg::OFF_PROT_CFG))
          begin
            // The user flags only change through the stored byte.
            next_st.cfg.open_for_modify = avs_writedata_in[eesp_pkg::POS_OPEN];
            next_st.cfg.range_protect_off = avs_writedata_in[eesp_pkg::POS_RANGE_OFF];
            next_st.cfg.protect_size_sel = avs_writedata_in[eesp_pkg::POS_SIZE_LO +: 3];
          end
          else if (hits(avs_address_in, eesp_pkg::OFF_ARRAY_STATUS))
          begin
            if (avs_writedata_in[eesp_pkg::POS_VIOLATION])
            begin
              next_st.violation = 1'b0;
            end
          end
          else if (hits(avs_address_in, eesp_pkg::OFF_IRQ_CLEAR))
          begin
            next_st.irq_stat = st.irq_stat & ~avs_writedata_in[eesp_pkg::IRQ_W-1:0];
          end
          else if (hits(avs_address_in, eesp_pkg::OFF_IRQ_ENABLE))
          begin
            next_st.irq_en = avs_writedata_in[eesp_pkg::IRQ_W-1:0];
          end
        end
      end
      default:
      begin
        next_st.wait_req = 1'b1;
        next_st.bus_st = eesp_pkg::EESP_BUS_IDLE;
      end
    endcase

    // Events come after the clears so that a set in the same cycle wins.
    if (cmd_valid_in)
    begin
      if (cmd_allowed)
      begin
        next_st.allow = 1'b1;
        next_st.irq_stat[eesp_pkg::IRQ_ALLOWED] = 1'b1;
      end
      else
      begin
        next_st.deny = 1'b1;
        next_st.violation = 1'b1;
        next_st.irq_stat[eesp_pkg::IRQ_VIOLATION] = 1'b1;
      end
    end

    next_st.irq = |(next_st.irq_stat & next_st.irq_en);

    if (srst_in)
    begin
      // The stored byte decides protection before the first request is served.
      next_st.cfg = stored_prot_in;
      next_st.violation = 1'b0;
      next_st.irq_stat = eesp_pkg::IRQ_STAT_RESET;
      next_st.irq_en = eesp_pkg::IRQ_EN_RESET;
      next_st.bus_st = eesp_pkg::EESP_BUS_IDLE;
      next_st.wait_req = 1'b1;
      next_st.rdata = eesp_pkg::RDATA_RESET;
      next_st.allow = 1'b0;
      next_st.deny = 1'b0;
      next_st.irq = 1'b0;
    end
  end

  // Reset acts even while the enable is low, so a frozen block still starts clean.
  always_ff @(posedge clk_in)
  begin
    if (ce_in || srst_in)
    begin
      st <= next_st;
    end
  end

  always_comb
  begin
    avs_readdata_out = st.rdata;
    avs_waitrequest_out = st.wait_req;
    cmd_allow_out = st.allow;
    cmd_deny_out = st.deny;
    prot_cfg_out = st.cfg;
    irq_out = st.irq;
  end

endmodule // eesp_top

// file: verification/eesp_asserts.sv
`timescale 1ns/10ps
module eesp_asserts (
  // Watched ports
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire eesp_pkg::eesp_prot_cfg_t stored_prot_in,
  input wire logic cmd_valid_in,
  input wire eesp_pkg::eesp_cmd_t cmd_in,
  input wire logic cmd_allow_out,
  input wire logic cmd_deny_out,
  input wire eesp_pkg::eesp_prot_cfg_t prot_cfg_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  logic go;
  logic pgm;
  logic mass;
  logic open;
  logic off;
  logic [11:0] base;
  assign go = cmd_valid_in && ce_in;
  assign pgm = cmd_in.kind == eesp_pkg::EESP_CMD_PROGRAM;
  assign mass = cmd_in.kind == eesp_pkg::EESP_CMD_MASS_ERASE;
  assign open = prot_cfg_out.open_for_modify;
  assign off = prot_cfg_out.range_protect_off;
  assign base = 12'h800 - {2'h0, {1'b0, prot_cfg_out.protect_size_sel} + 4'h1, 6'h00};
  one_verdict_a: assert property (go |=> cmd_allow_out ^ cmd_deny_out)
    else $error("verdict not exactly one");
  closed_deny_a: assert property (go && !open |=> cmd_deny_out)
    else $error("closed array allowed");
  mass_ok_a: assert property (go && mass && open && off |=> cmd_allow_out)
    else $error("mass erase refused");
  mass_deny_a: assert property (go && mass && !(open && off) |=> cmd_deny_out)
    else $error("mass erase allowed");
  range_off_a: assert property (go && pgm && open && off |=> cmd_allow_out)
    else $error("unprotected program refused");
  sector_size_a: assert property (go && pgm && open && !off |=> cmd_deny_out == $past({1'b0, cmd_in.addr} >= base))
    else $error("sector bound wrong");
  nv_hold_a: assert property (!srst_in |=> $stable(prot_cfg_out.user_nv_flags))
    else $error("user flags changed");
  reset_load_a: assert property (disable iff (1'b0) srst_in |=> prot_cfg_out == $past(stored_prot_in))
    else $error("config not loaded");
endmodule // eesp_asserts
bind eesp_top eesp_asserts i_eesp_asserts (.clk_in(clk_in), .srst_in(srst_in), .ce_in(ce_in),
  .stored_prot_in(stored_prot_in), .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in),
  .cmd_allow_out(cmd_allow_out), .cmd_deny_out(cmd_deny_out), .prot_cfg_out(prot_cfg_out));

// file: verification/eesp_top_tb.sv
`timescale 1ns/10ps
module eesp_top_tb;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic vld = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic wreq;
  logic irq;
  logic allow;
  logic deny;
  eesp_pkg::eesp_prot_cfg_t stored = 8'h5a;
  eesp_pkg::eesp_prot_cfg_t cfg;
  eesp_pkg::eesp_cmd_t cmd = 13'h0;
  int failures = 0;
  int n_compared = 0;
  // Clock enable and byte lanes are tied on; freezing is not exercised.
  eesp_top i_eesp_top (.clk_in(clk_in), .srst_in(srst_in), .ce_in(1'b1), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(4'hf),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wreq), .stored_prot_in(stored), .cmd_valid_in(vld),
    .cmd_in(cmd), .cmd_allow_out(allow), .cmd_deny_out(deny), .prot_cfg_out(cfg), .irq_out(irq));
  initial
  begin
    forever #2 clk_in = ~clk_in;
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask
  // Waitrequest and read data are read right at the rising edge, before that edge updates them.
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_in);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    do @(posedge clk_in); while (wreq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rchk(input string name, input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(name, exp, q);
  endtask
  task automatic op(input logic [1:0] k, input logic [10:0] a, input logic ok);
    @(posedge clk_in);
    vld <= 1'b1;
    cmd <= {k, a};
    @(posedge clk_in);
    vld <= 1'b0;
    #1;
    chk("verdict", {30'h0, ok, !ok}, {30'h0, allow, deny});
  endtask
  task automatic irq_chk(input logic exp);
    repeat (2) @(posedge clk_in);
    #1;
    chk("irq_out", {31'h0, exp}, {31'h0, irq});
  endtask
  task automatic rst();
    @(posedge clk_in);
    srst_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    srst_in <= 1'b0;
    #1;
    chk("prot_cfg_out", {24'h0, stored}, {24'h0, cfg});
  endtask
  task automatic test_done();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    rst();
    rchk("protection_config", 5'h00, 32'h5a);
    op(2'h0, 11'h000, 1'b0);
    rchk("array_status", 5'h04, 32'h1);
    bus(1'b1, 5'h10, 32'h1);
    irq_chk(1'b1);
    bus(1'b1, 5'h0c, 32'h3);
    bus(1'b1, 5'h04, 32'h1);
    irq_chk(1'b0);
    bus(1'b1, 5'h10, 32'h0);
    op(2'h1, 11'h000, 1'b0);
    irq_chk(1'b0);
    rchk("irq_status", 5'h08, 32'h1);
    rchk("unmapped", 5'h14, 32'h0);
    for (int s = 0; s < 8; s++)
    begin
      bus(1'b1, 5'h00, 32'h80 | s);
      op(2'h0, 11'h7bf - 11'(64 * s), 1'b1);
      op(2'h1, 11'h7c0 - 11'(64 * s), 1'b0);
    end
    rchk("protection_config", 5'h00, 32'hd7);
    op(2'h0, 11'h7fd, 1'b0);
    op(2'h2, 11'h000, 1'b0);
    bus(1'b1, 5'h00, 32'h88);
    op(2'h0, 11'h7fd, 1'b1);
    op(2'h2, 11'h000, 1'b1);
    op(2'h3, 11'h000, 1'b0);
    rchk("array_status", 5'h04, 32'h3);
    bus(1'b1, 5'h00, 32'h08);
    op(2'h2, 11'h000, 1'b0);
    op(2'h0, 11'h000, 1'b0);
    stored <= 8'h2b;
    rst();
    test_done();
  end
  initial
  begin
    repeat (3000) @(posedge clk_in);
    failures++;
    test_done();
  end
endmodule // eesp_top_tb
